// ### common/spx_map.vh
// register offsets, reset values and paging constants of the sfr page block
`ifndef SPX_MAP_VH
`define SPX_MAP_VH
`define SPX_SFR_BASE 8'h80
`define SPX_ADDR_CTRL 8'h84
`define SPX_ADDR_MIDDLE 8'h85
`define SPX_ADDR_BOTTOM 8'h86
`define SPX_ADDR_ACTIVE 8'ha7
`define SPX_ADDR_XPAGE 8'haa
`define SPX_PAGE_ZERO 8'h00
`define SPX_PAGE_HIGH 8'h0f
`define SPX_IRQ_PAGE 8'h00
`define SPX_RST_ACTIVE 8'h00
`define SPX_RST_MIDDLE 8'h00
`define SPX_RST_BOTTOM 8'h00
`define SPX_RST_XPAGE 8'h00
`define SPX_RST_AUTOPG 1'b1
`define SPX_AUTOPG_BIT 0
`define SPX_BIT_NIB_A 4'h0
`define SPX_BIT_NIB_B 4'h8
`define SPX_SEL_NONE 4'h0
`define SPX_SEL_CTRL 4'h1
`define SPX_SEL_MIDDLE 4'h2
`define SPX_SEL_BOTTOM 4'h3
`define SPX_SEL_ACTIVE 4'h4
`define SPX_SEL_XPAGE 4'h5
`endif

// ### hw/spx_decode.v
// address decoder for the paged special function register space
`timescale 1ns/100ps
`default_nettype none
`include "spx_map.vh"
module spx_decode (
    input wire [7:0] addr,
    input wire [7:0] page,
    input wire direct,
    output reg is_sfr,
    output reg bit_ok,
    output reg [3:0] sel,
    output reg all_pages
);
    always @* begin
        is_sfr = direct && addr[7];
        // bit access on x0 and x8
        bit_ok = is_sfr && (addr[3:0] == `SPX_BIT_NIB_A || addr[3:0] == `SPX_BIT_NIB_B);
        sel = `SPX_SEL_NONE;
        all_pages = 1'b0;
        if (is_sfr) begin
            case (addr)
                `SPX_ADDR_ACTIVE: begin
                    sel = `SPX_SEL_ACTIVE;
                    all_pages = 1'b1;
                end
                `SPX_ADDR_MIDDLE: begin
                    sel = `SPX_SEL_MIDDLE;
                    all_pages = 1'b1;
                end
                `SPX_ADDR_BOTTOM: begin
                    sel = `SPX_SEL_BOTTOM;
                    all_pages = 1'b1;
                end
                `SPX_ADDR_CTRL: begin
                    if (page == `SPX_PAGE_HIGH) begin
                        sel = `SPX_SEL_CTRL;
                    end
                end
                `SPX_ADDR_XPAGE: begin
                    if (page == `SPX_PAGE_ZERO) begin
                        sel = `SPX_SEL_XPAGE;
                    end
                end
                default: begin
                    sel = `SPX_SEL_NONE;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// ### hw/spx_stack.v
// three-entry sfr page stack with push, pop and software writes
`timescale 1ns/100ps
`default_nettype none
`include "spx_map.vh"
module spx_stack (
    input wire clk,
    input wire rst_n,
    input wire push,
    input wire pop,
    input wire wr_active,
    input wire wr_middle,
    input wire wr_bottom,
    input wire [7:0] wdata,
    output reg [7:0] active_q,
    output reg [7:0] middle_q,
    output reg [7:0] bottom_q
);
    always @(posedge clk) begin
        if (!rst_n) begin
            active_q <= `SPX_RST_ACTIVE;
            middle_q <= `SPX_RST_MIDDLE;
            bottom_q <= `SPX_RST_BOTTOM;
        end else if (push) begin
            bottom_q <= middle_q;
            middle_q <= active_q;
            active_q <= `SPX_IRQ_PAGE;
        end else if (pop) begin
            active_q <= middle_q;
            middle_q <= bottom_q;
            bottom_q <= `SPX_PAGE_ZERO;
        end else begin
            if (wr_active) begin
                active_q <= wdata;
            end
            if (wr_middle) begin
                middle_q <= wdata;
            end
            if (wr_bottom) begin
                bottom_q <= wdata;
            end
        end
    end
endmodule
`default_nettype wire

// ### hw/spx_sfr_page.v
// sfr paging, page stack and xram page register of the core
`timescale 1ns/100ps
`default_nettype none
`include "spx_map.vh"
// Operation
// - 8-bit external move takes high address byte from xram page bits.
// - direct access at 0x80 and above goes to sfr space.
// - sfrs at low nibble 0 or 8 are bit addressable too.
// - 8-bit page number; only pages zero and fifteen populated.
// - interrupt entry pushes: middle to bottom, active to middle.
// - after push, active page loads page zero.
// - interrupt return pops: middle to active, bottom to middle.
// - empty bottom delivers zero into middle on pop.
// - software writes to stack registers never push or pop.
// - all three stack entries readable and writable by software.
// - push overwrites bottom entry unconditionally.
// - automatic paging enable is set by reset.
// - cleared enable stops page load, push and pop.
// - all-page registers decode regardless of active page.
// - active page writable except in a push or pop cycle, applies to later accesses.
// - active page register at 0xa7 on all pages, reset zero.
// - control register at 0x84 on page fifteen, bit 0 only.
// - middle entry register at 0x85 on all pages, reset zero.
// - external move low byte from named index register.
module spx_sfr_page (
    input wire clk,
    input wire rst_n,
    input wire sfr_direct,
    input wire [7:0] sfr_addr,
    input wire sfr_wr,
    input wire sfr_rd,
    input wire sfr_bit,
    input wire [2:0] sfr_bit_pos,
    input wire [7:0] sfr_wdata,
    input wire irq_enter,
    input wire irq_return,
    input wire xmove_short,
    input wire xmove_idx_sel,
    input wire [7:0] idx_reg_zero,
    input wire [7:0] idx_reg_one,
    input wire [15:0] xmove_long_addr,
    output reg [7:0] sfr_rdata,
    output reg sfr_hit,
    output reg sfr_bit_err,
    output reg [7:0] page_sel,
    output reg sfr_space,
    output reg [15:0] xram_addr,
    output reg autopage_enable
);
    // ======================================================================
    // declarations
    wire is_sfr;
    wire bit_ok;
    wire [3:0] sel;
    wire [7:0] active_q;
    wire [7:0] middle_q;
    wire [7:0] bottom_q;
    reg [7:0] xpage_q;
    reg autopg_q;
    reg [7:0] rdata_d;
    reg [7:0] byte_d;
    reg [7:0] merged;
    reg [7:0] sfr_rdata_d;
    reg sfr_hit_d;
    reg sfr_bit_err_d;
    reg [7:0] page_sel_d;
    reg sfr_space_d;
    reg [15:0] xram_addr_d;
    reg autopage_enable_d;
    wire acc_any;
    wire bit_acc;
    wire wr_ok;
    wire do_push;
    wire do_pop;
    wire wr_active;
    wire wr_middle;
    wire wr_bottom;
    wire wr_ctrl;
    wire wr_xpage;
    wire [7:0] idx_byte;

    // ======================================================================
    // helper functions
    // true when the decoded select names the given register
    function sel_is;
        input [3:0] code_sel;
        input [3:0] code_ref;
        begin
            sel_is = (code_sel == code_ref);
        end
    endfunction

    // byte view of one of this block's registers
    function [7:0] reg_pick;
        input [3:0] code_sel;
        input [7:0] act;
        input [7:0] mid;
        input [7:0] bot;
        input ctl;
        input [7:0] xpg;
        begin
            case (code_sel)
                `SPX_SEL_ACTIVE: reg_pick = act;
                `SPX_SEL_MIDDLE: reg_pick = mid;
                `SPX_SEL_BOTTOM: reg_pick = bot;
                `SPX_SEL_CTRL: reg_pick = {7'h00, ctl};
                `SPX_SEL_XPAGE: reg_pick = xpg;
                default: reg_pick = 8'h00;
            endcase
        end
    endfunction

    // one bit replaced, rest of the byte kept
    function [7:0] bit_merge;
        input [7:0] old_byte;
        input [2:0] pos;
        input new_bit;
        reg [7:0] tmp;
        begin
            tmp = old_byte;
            tmp[pos] = new_bit;
            bit_merge = tmp;
        end
    endfunction

    // one bit moved down to bit 0
    function [7:0] bit_pick;
        input [7:0] src_byte;
        input [2:0] pos;
        begin
            bit_pick = {7'h00, src_byte[pos]};
        end
    endfunction

    // page byte on top, low byte below
    function [15:0] xram_join;
        input [7:0] hi_byte;
        input [7:0] lo_byte;
        begin
            xram_join = {hi_byte, lo_byte};
        end
    endfunction

    // ======================================================================
    // address decode
    spx_decode u_dec (
        .addr(sfr_addr),
        .page(active_q),
        .direct(sfr_direct),
        .is_sfr(is_sfr),
        .bit_ok(bit_ok),
        .sel(sel),
        .all_pages()
    );

    // ======================================================================
    // access qualifiers and write strobes
    assign acc_any = sfr_rd || sfr_wr;
    // bit access needs x0 or x8 address
    assign bit_acc = sfr_bit && bit_ok;
    // bit writes to byte-only registers are dropped whole
    assign wr_ok = sfr_wr && (!sfr_bit || bit_ok);
    // active page written on any page
    assign wr_active = wr_ok && sel_is(sel, `SPX_SEL_ACTIVE);
    // middle entry written on any page
    assign wr_middle = wr_ok && sel_is(sel, `SPX_SEL_MIDDLE);
    // bottom entry written on any page
    assign wr_bottom = wr_ok && sel_is(sel, `SPX_SEL_BOTTOM);
    // control written on page fifteen only
    assign wr_ctrl = wr_ok && sel_is(sel, `SPX_SEL_CTRL);
    // xram page written on page zero only
    assign wr_xpage = wr_ok && sel_is(sel, `SPX_SEL_XPAGE);

    // ======================================================================
    // read and write merge
    always @* begin
        byte_d = reg_pick(sel, active_q, middle_q, bottom_q, autopg_q, xpage_q);
        merged = sfr_wdata;
        if (bit_acc) begin
            merged = bit_merge(byte_d, sfr_bit_pos, sfr_wdata[0]);
        end
        rdata_d = byte_d;
        if (bit_acc) begin
            rdata_d = bit_pick(byte_d, sfr_bit_pos);
        end
    end

    // ======================================================================
    // stack operation requests
    // gate stack ops by enable
    assign do_push = irq_enter && autopg_q;
    // entry wins when both strobes meet, so no page is lost
    assign do_pop = irq_return && autopg_q && !irq_enter;

    // ======================================================================
    // page stack
    // push and pop never reach the stack in the same cycle
    spx_stack u_stk (
        .clk(clk),
        .rst_n(rst_n),
        .push(do_push),
        .pop(do_pop),
        .wr_active(wr_active),
        .wr_middle(wr_middle),
        .wr_bottom(wr_bottom),
        .wdata(merged),
        .active_q(active_q),
        .middle_q(middle_q),
        .bottom_q(bottom_q)
    );

    // ======================================================================
    // automatic paging enable
    always @(posedge clk) begin
        if (!rst_n) begin
            autopg_q <= `SPX_RST_AUTOPG;
        end else if (wr_ctrl) begin
            autopg_q <= merged[`SPX_AUTOPG_BIT];
        end
    end

    // ======================================================================
    // xram page register
    always @(posedge clk) begin
        if (!rst_n) begin
            xpage_q <= `SPX_RST_XPAGE;
        end else if (wr_xpage) begin
            xpage_q <= merged;
        end
    end

    assign idx_byte = xmove_idx_sel ? idx_reg_one : idx_reg_zero;

    // ======================================================================
    // next values of the registered outputs
    always @* begin
        // read data is zero when no read is made
        sfr_rdata_d = 8'h00;
        if (sfr_rd) begin
            sfr_rdata_d = rdata_d;
        end
        sfr_hit_d = acc_any && !sel_is(sel, `SPX_SEL_NONE);
        sfr_bit_err_d = acc_any && sfr_bit && is_sfr && !bit_ok;
        page_sel_d = active_q;
        // route direct upper half to sfr
        sfr_space_d = is_sfr;
        if (xmove_short) begin
            xram_addr_d = xram_join(xpage_q, idx_byte);
        end else begin
            xram_addr_d = xmove_long_addr;
        end
        autopage_enable_d = autopg_q;
    end

    // ======================================================================
    // read data output
    always @(posedge clk) begin
        if (!rst_n) begin
            sfr_rdata <= 8'h00;
        end else begin
            sfr_rdata <= sfr_rdata_d;
        end
    end

    // ======================================================================
    // register hit output
    always @(posedge clk) begin
        if (!rst_n) begin
            sfr_hit <= 1'b0;
        end else begin
            sfr_hit <= sfr_hit_d;
        end
    end

    // ======================================================================
    // bit access error output
    always @(posedge clk) begin
        if (!rst_n) begin
            sfr_bit_err <= 1'b0;
        end else begin
            sfr_bit_err <= sfr_bit_err_d;
        end
    end

    // ======================================================================
    // page select output
    always @(posedge clk) begin
        if (!rst_n) begin
            page_sel <= `SPX_RST_ACTIVE;
        end else begin
            page_sel <= page_sel_d;
        end
    end

    // ======================================================================
    // sfr space output
    always @(posedge clk) begin
        if (!rst_n) begin
            sfr_space <= 1'b0;
        end else begin
            sfr_space <= sfr_space_d;
        end
    end

    // ======================================================================
    // xram address output
    always @(posedge clk) begin
        if (!rst_n) begin
            xram_addr <= 16'h0000;
        end else begin
            xram_addr <= xram_addr_d;
        end
    end

    // ======================================================================
    // paging enable output
    always @(posedge clk) begin
        if (!rst_n) begin
            autopage_enable <= `SPX_RST_AUTOPG;
        end else begin
            autopage_enable <= autopage_enable_d;
        end
    end
endmodule
`default_nettype wire

// ### dv/spx_sva.sv
// assertion checker on the sfr page block ports
`timescale 1ns/100ps
`default_nettype none
module spx_sva (
    input wire clk,
    input wire rst_n,
    input wire sfr_direct,
    input wire [7:0] sfr_addr,
    input wire sfr_wr,
    input wire sfr_rd,
    input wire sfr_bit,
    input wire irq_enter,
    input wire xmove_short,
    input wire xmove_idx_sel,
    input wire [7:0] idx_reg_zero,
    input wire [15:0] xmove_long_addr,
    input wire [7:0] sfr_rdata,
    input wire sfr_bit_err,
    input wire [7:0] page_sel,
    input wire sfr_space,
    input wire [15:0] xram_addr,
    input wire autopage_enable
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    wire acc = sfr_rd | sfr_wr;
    space_route_a: assert property (sfr_direct && acc && sfr_addr[7] |=> sfr_space)
        else $error("sfr space not flagged");
    bit_err_a: assert property (sfr_direct && acc && sfr_bit && sfr_addr[7]
        && sfr_addr[2:0] != 3'h0 |=> sfr_bit_err) else $error("bit error missing");
    low_byte_a: assert property (xmove_short && !xmove_idx_sel
        |=> xram_addr[7:0] == $past(idx_reg_zero)) else $error("low byte wrong");
    long_addr_a: assert property (!xmove_short
        |=> xram_addr == $past(xmove_long_addr)) else $error("long address wrong");
    push_page_a: assert property (irq_enter && autopage_enable && !$past(sfr_wr)
        |-> ##2 page_sel == 8'h00) else $error("page not zero on entry");
    no_auto_a: assert property (irq_enter && !autopage_enable && !sfr_wr && !$past(sfr_wr)
        ##1 !sfr_wr |=> $stable(page_sel)) else $error("page moved while disabled");
    idle_read_a: assert property (!sfr_rd |=> sfr_rdata == 8'h00)
        else $error("read data not idle");
    ctrl_upper_a: assert property (sfr_rd && sfr_direct && sfr_addr == 8'h84
        |=> sfr_rdata[7:1] == 7'h00) else $error("control upper bits set");
endmodule
bind spx_sfr_page spx_sva spx_sva_inst (.*);
`default_nettype wire

// ### dv/spx_core_model.sv
// behavioural core driving the sfr page block
`timescale 1ns/100ps
`default_nettype none
module spx_core_model (
    input wire clk,
    output logic sfr_direct,
    output logic [7:0] sfr_addr,
    output logic sfr_wr,
    output logic sfr_rd,
    output logic sfr_bit,
    output logic [2:0] sfr_bit_pos,
    output logic [7:0] sfr_wdata,
    output logic irq_enter,
    output logic irq_return,
    output logic xmove_short,
    output logic xmove_idx_sel,
    output logic [7:0] idx_reg_zero,
    output logic [7:0] idx_reg_one,
    output logic [15:0] xmove_long_addr
);
    initial begin
        {sfr_direct, sfr_addr, sfr_wr, sfr_rd, sfr_bit, sfr_bit_pos, sfr_wdata} = '0;
        {irq_enter, irq_return, xmove_short, xmove_idx_sel} = '0;
        {idx_reg_zero, idx_reg_one, xmove_long_addr} = '0;
    end
    task automatic acc(input [7:0] a, input [7:0] d, input w, input b, input [2:0] p, input dr);
        @(negedge clk);
        {sfr_direct, sfr_addr, sfr_wdata, sfr_wr, sfr_rd, sfr_bit, sfr_bit_pos} =
            {dr, a, d, w, !w, b, p};
        @(negedge clk);
        {sfr_direct, sfr_wr, sfr_rd, sfr_bit} = '0;
    endtask
    task automatic irq(input e);
        @(negedge clk);
        {irq_enter, irq_return} = {e, !e};
        @(negedge clk);
        {irq_enter, irq_return} = '0;
    endtask
    task automatic xm(input s, input i, input [7:0] z, input [7:0] o, input [15:0] l);
        @(negedge clk);
        {xmove_short, xmove_idx_sel, idx_reg_zero, idx_reg_one, xmove_long_addr} = {s, i, z, o, l};
        @(negedge clk);
    endtask
endmodule
`default_nettype wire

// ### dv/tb_spx_sfr_page.sv
// self-checking bench for the sfr page block
`timescale 1ns/100ps
`default_nettype none
module tb_spx_sfr_page;
    logic clk, rst_n;
    wire sfr_direct, sfr_wr, sfr_rd, sfr_bit, irq_enter, irq_return, xmove_short, xmove_idx_sel;
    wire [2:0] sfr_bit_pos;
    wire [7:0] sfr_addr, sfr_wdata, idx_reg_zero, idx_reg_one, sfr_rdata, page_sel;
    wire [15:0] xmove_long_addr, xram_addr;
    wire sfr_hit, sfr_bit_err, sfr_space, autopage_enable;
    int n_errors = 0;
    int samples_checked = 0;
    spx_core_model spx_core_model_inst (.*);
    spx_sfr_page spx_sfr_page_inst (.*);
    initial begin
        clk = 0;
        forever #5 clk = ~clk;
    end
    task automatic chk(input [15:0] got, input [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input [7:0] a, input [7:0] d);
        spx_core_model_inst.acc(a, d, 1'b1, 1'b0, 3'h0, 1'b1);
    endtask
    task automatic rc(input [7:0] a, input [7:0] e);
        spx_core_model_inst.acc(a, 8'h00, 1'b0, 1'b0, 3'h0, 1'b1);
        chk(sfr_rdata, e);
        chk(sfr_hit, 1);
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        #200000;
        n_errors++;
        report_and_stop();
    end
    initial begin
        rst_n = 0;
        repeat (2) @(negedge clk);
        rst_n = 1;
        chk(autopage_enable, 1);
        rc(8'ha7, 8'h00);
        rc(8'h85, 8'h00);
        rc(8'h86, 8'h00);
        rc(8'haa, 8'h00);
        wr(8'ha7, 8'h0f);
        rc(8'h84, 8'h01);
        $display("reset test done");
        wr(8'h86, 8'h33);
        rc(8'h86, 8'h33);
        rc(8'ha7, 8'h0f);
        spx_core_model_inst.irq(1'b1);
        rc(8'ha7, 8'h00);
        chk(page_sel, 8'h00);
        rc(8'h85, 8'h0f);
        rc(8'h86, 8'h00);
        spx_core_model_inst.irq(1'b1);
        rc(8'h86, 8'h0f);
        spx_core_model_inst.irq(1'b0);
        rc(8'ha7, 8'h00);
        rc(8'h85, 8'h0f);
        spx_core_model_inst.irq(1'b0);
        rc(8'ha7, 8'h0f);
        $display("stack test done");
        wr(8'h85, 8'h55);
        wr(8'h84, 8'h00);
        @(negedge clk);
        chk(autopage_enable, 0);
        spx_core_model_inst.irq(1'b1);
        rc(8'ha7, 8'h0f);
        chk(page_sel, 8'h0f);
        spx_core_model_inst.irq(1'b0);
        rc(8'ha7, 8'h0f);
        rc(8'h85, 8'h55);
        wr(8'h84, 8'h01);
        $display("disable test done");
        wr(8'ha7, 8'h00);
        spx_core_model_inst.acc(8'h84, 8'h00, 1'b0, 1'b0, 3'h0, 1'b1);
        chk(sfr_hit, 0);
        chk(sfr_rdata, 0);
        spx_core_model_inst.acc(8'ha7, 8'h77, 1'b1, 1'b0, 3'h0, 1'b0);
        chk(sfr_space, 0);
        spx_core_model_inst.acc(8'ha7, 8'h01, 1'b1, 1'b1, 3'h2, 1'b1);
        chk(sfr_bit_err, 1);
        rc(8'ha7, 8'h00);
        chk(sfr_space, 1);
        wr(8'haa, 8'h12);
        rc(8'haa, 8'h12);
        spx_core_model_inst.xm(1'b1, 1'b0, 8'h34, 8'h56, 16'habcd);
        chk(xram_addr, 16'h1234);
        spx_core_model_inst.xm(1'b1, 1'b1, 8'h34, 8'h56, 16'habcd);
        chk(xram_addr, 16'h1256);
        spx_core_model_inst.xm(1'b0, 1'b0, 8'h34, 8'h56, 16'habcd);
        chk(xram_addr, 16'habcd);
        spx_core_model_inst.acc(8'ha7, 8'h00, 1'b0, 1'b1, 3'h3, 1'b1);
        chk(sfr_bit_err, 1);
        $display("xram test done");
        report_and_stop();
    end
endmodule
`default_nettype wire
